// [design/rfpg_defines.vh]
// How it works
// - a rail losing regulation sets its fault flag; ten rails over two registers
// - writing 0 to a fault flag clears it; a flag reading 1 means fault
// - mask bit 0 passes the rail's real power-good into the combined tree
// - mask bit 1 forces the rail's power-good to 1, removing it from the tree
`ifndef RFPG_DEFINES_VH
`define RFPG_DEFINES_VH

// register indices; byte address is four times the index
`define RFPG_IDX_STAT_A 10'h016
`define RFPG_IDX_STAT_B 10'h017
`define RFPG_IDX_MASK_A 10'h018
`define RFPG_IDX_MASK_B 10'h019
`define RFPG_IDX_IRQ_STAT 10'h01a
`define RFPG_IDX_IRQ_MASK 10'h01b
`define RFPG_IDX_PG_STATE 10'h01c

// reset values
`define RFPG_RST_STAT_A 8'h00
`define RFPG_RST_STAT_B 2'h0
`define RFPG_RST_MASK_A 8'h00
`define RFPG_RST_MASK_B 4'h0
`define RFPG_RST_IRQ_STAT 4'h0
`define RFPG_RST_IRQ_MASK 4'hf

// field widths
`define RFPG_W_STAT_A 8
`define RFPG_W_STAT_B 2
`define RFPG_W_MASK_A 8
`define RFPG_W_MASK_B 4
`define RFPG_W_IRQ 4

// fault fields of status a
`define RFPG_IO_CORE_RAIL_FAULT 7
`define RFPG_FIVE_VOLT_STANDBY_RAIL_FAULT 6
`define RFPG_DEEP_SLEEP_3V3_RAIL_FAULT 5
`define RFPG_CHIPSET_3V3_RAIL_FAULT 4
`define RFPG_ALWAYS_ON_1V8_RAIL_FAULT 3
`define RFPG_SWITCHED_1V8_2V5_RAIL_FAULT 2
`define RFPG_SWITCHED_1V2_RAIL_FAULT 1
`define RFPG_MEMORY_TERMINATION_RAIL_FAULT 0
// fault fields of status b
`define RFPG_ALWAYS_ON_1V0_RAIL_FAULT 1
`define RFPG_ALWAYS_ON_0V85_RAIL_FAULT 0

// mask fields of mask a
`define RFPG_IO_CORE_GOOD_MASK 7
`define RFPG_ALWAYS_ON_0V85_GOOD_MASK 6
`define RFPG_ALWAYS_ON_1V0_GOOD_MASK 5
`define RFPG_ALWAYS_ON_1V8_GOOD_MASK 4
`define RFPG_CHIPSET_3V3_GOOD_MASK 3
`define RFPG_FIVE_VOLT_STANDBY_GOOD_MASK 2
`define RFPG_DEEP_SLEEP_3V3_GOOD_MASK 1
`define RFPG_SLEEP_1V0_GOOD_MASK 0
// mask fields of mask b
`define RFPG_SWITCHED_1V8_2V5_GOOD_MASK 3
`define RFPG_SWITCHED_1V2_GOOD_MASK 2
`define RFPG_SLEEP_3V3_GOOD_MASK 1
`define RFPG_SLEEP_1V8_GOOD_MASK 0

// interrupt status / mask bits
`define RFPG_IRQ_FAULT_A 0
`define RFPG_IRQ_FAULT_B 1
`define RFPG_IRQ_TREE_FELL 2
`define RFPG_IRQ_TREE_ROSE 3

// pg state register layout
`define RFPG_PGS_RAW_LSB 0
`define RFPG_PGS_EFF_LSB 12
`define RFPG_PGS_TREE 24

// clear polarity of sticky flags
`define RFPG_CLR_ON_ZERO 1'b0
`define RFPG_CLR_ON_ONE 1'b1

`endif

// [design/rfpg_sticky_flags.v]
`timescale 1ns/1ps
`include "rfpg_defines.vh"

// bank of sticky flags: hardware sets, software clears by writing CLR_VAL
module rfpg_sticky_flags #(
    parameter W = 8,
    parameter [W-1:0] RST_VAL = {W{1'b0}},
    parameter CLR_VAL = 1'b0
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // hardware events
    input wire [W-1:0] set_in,
    // software write
    input wire wr_en,
    input wire [W-1:0] wdata,
    // flags
    output reg [W-1:0] flags
);

    wire [W-1:0] clr_hit;
    wire [W-1:0] next_flags;

    // a set in the same cycle as a clear wins, so no event is lost
    assign clr_hit = wr_en ? (CLR_VAL ? wdata : ~wdata) : {W{1'b0}};
    assign next_flags = (flags & ~clr_hit) | set_in;

    // flag storage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= RST_VAL;
        end else begin
            flags <= next_flags;
        end
    end

endmodule // rfpg_sticky_flags

// [design/rfpg_regs.v]
`timescale 1ns/1ps
`include "rfpg_defines.vh"

// rail fault latches and power-good tree masks, reached over apb
module rfpg_regs #(
    parameter AW = 12
) (
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [AW-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    // loss-of-regulation indications, high while the rail is out
    input wire [`RFPG_W_STAT_A-1:0] rail_lost_a,
    input wire [`RFPG_W_STAT_B-1:0] rail_lost_b,
    // raw power-good from the rail monitors, same bit order as the masks
    input wire [`RFPG_W_MASK_A-1:0] rail_pg_a,
    input wire [`RFPG_W_MASK_B-1:0] rail_pg_b,
    // power-good after masking
    output reg [`RFPG_W_MASK_A-1:0] rail_pg_eff_a,
    output reg [`RFPG_W_MASK_B-1:0] rail_pg_eff_b,
    output reg power_good_tree,
    // interrupt
    output wire irq
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    wire [9:0] idx;
    wire setup_ph;
    wire access_ph;
    wire wr_acc;
    wire lane0;
    reg hit_stat_a;
    reg hit_stat_b;
    reg hit_mask_a;
    reg hit_mask_b;
    reg hit_irq_stat;
    reg hit_irq_mask;
    reg hit_pg_state;
    wire mapped;
    // write strobes, one per writable register
    wire wr_stat_a;
    wire wr_stat_b;
    wire wr_mask_a;
    wire wr_mask_b;
    wire wr_irq_stat;
    wire wr_irq_mask;
    wire [`RFPG_W_STAT_A-1:0] fault_a;
    wire [`RFPG_W_STAT_B-1:0] fault_b;
    wire [`RFPG_W_IRQ-1:0] irq_stat;
    wire [`RFPG_W_IRQ-1:0] irq_events;
    reg [`RFPG_W_MASK_A-1:0] mask_a;
    reg [`RFPG_W_MASK_B-1:0] mask_b;
    reg [`RFPG_W_IRQ-1:0] irq_mask;
    reg [`RFPG_W_MASK_A-1:0] next_eff_a;
    reg [`RFPG_W_MASK_B-1:0] next_eff_b;
    reg next_tree;
    reg tree_prev;
    reg [31:0] next_rdata;

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    // word index; the two low address bits are ignored for aligned words
    assign idx = paddr[11:2];
    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    // only byte lane 0 carries write data, all writable fields are 8 bits or less
    // a write with that strobe low is dropped without an error
    assign lane0 = pstrb[0];
    assign wr_acc = access_ph & pwrite & lane0 & ~pslverr;

    // register selects; an index outside the map raises none of them
    always @* begin
        hit_stat_a = 1'b0;
        hit_stat_b = 1'b0;
        hit_mask_a = 1'b0;
        hit_mask_b = 1'b0;
        hit_irq_stat = 1'b0;
        hit_irq_mask = 1'b0;
        hit_pg_state = 1'b0;
        case (idx)
            `RFPG_IDX_STAT_A: hit_stat_a = 1'b1;
            `RFPG_IDX_STAT_B: hit_stat_b = 1'b1;
            `RFPG_IDX_MASK_A: hit_mask_a = 1'b1;
            `RFPG_IDX_MASK_B: hit_mask_b = 1'b1;
            `RFPG_IDX_IRQ_STAT: hit_irq_stat = 1'b1;
            `RFPG_IDX_IRQ_MASK: hit_irq_mask = 1'b1;
            `RFPG_IDX_PG_STATE: hit_pg_state = 1'b1;
            default: hit_pg_state = 1'b0;
        endcase
    end

    // anything outside the map is refused with an error and no write
    assign mapped = hit_stat_a | hit_stat_b | hit_mask_a | hit_mask_b |
        hit_irq_stat | hit_irq_mask | hit_pg_state;

    ////////////////////////////////////////////////////////////////////////
    // write strobes

    // pg state has no strobe, so a write to it falls away
    assign wr_stat_a = wr_acc & hit_stat_a;
    assign wr_stat_b = wr_acc & hit_stat_b;
    assign wr_mask_a = wr_acc & hit_mask_a;
    assign wr_mask_b = wr_acc & hit_mask_b;
    assign wr_irq_stat = wr_acc & hit_irq_stat;
    assign wr_irq_mask = wr_acc & hit_irq_mask;

    ////////////////////////////////////////////////////////////////////////
    // fault status registers

    // status a: eight rails, write 0 clears, write 1 leaves the flag alone
    // a rail still out of regulation sets its flag again at once
    rfpg_sticky_flags #(
        .W(`RFPG_W_STAT_A),
        .RST_VAL(`RFPG_RST_STAT_A),
        .CLR_VAL(`RFPG_CLR_ON_ZERO)
    ) u_stat_a (
        .pclk(pclk),
        .presetn(presetn),
        .set_in(rail_lost_a),
        .wr_en(wr_stat_a),
        .wdata(pwdata[`RFPG_W_STAT_A-1:0]),
        .flags(fault_a)
    );

    // status b: two rails in bits 1:0, the upper bits are reserved
    // reserved bits are not stored, so software cannot leave them set
    rfpg_sticky_flags #(
        .W(`RFPG_W_STAT_B),
        .RST_VAL(`RFPG_RST_STAT_B),
        .CLR_VAL(`RFPG_CLR_ON_ZERO)
    ) u_stat_b (
        .pclk(pclk),
        .presetn(presetn),
        .set_in(rail_lost_b),
        .wr_en(wr_stat_b),
        .wdata(pwdata[`RFPG_W_STAT_B-1:0]),
        .flags(fault_b)
    );

    ////////////////////////////////////////////////////////////////////////
    // mask registers

    // mask a: a 1 forces the rail good, taking it out of the tree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_a <= `RFPG_RST_MASK_A;
        end else if (wr_mask_a) begin
            mask_a <= pwdata[`RFPG_W_MASK_A-1:0];
        end
    end

    // mask b: only bits 3:0 are stored, the reserved bits read back 0
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_b <= `RFPG_RST_MASK_B;
        end else if (wr_mask_b) begin
            mask_b <= pwdata[`RFPG_W_MASK_B-1:0];
        end
    end

    // interrupt mask resets all masked, so the rise after reset stays quiet
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= `RFPG_RST_IRQ_MASK;
        end else if (wr_irq_mask) begin
            irq_mask <= pwdata[`RFPG_W_IRQ-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power-good tree

    // a masked rail reads as good, an unmasked one passes its monitor
    // the tree therefore sees a masked rail as permanently good
    always @* begin
        next_eff_a = rail_pg_a | mask_a;
        next_eff_b = rail_pg_b | mask_b;
        next_tree = (&next_eff_a) & (&next_eff_b);
    end

    // registered so the outputs cannot glitch while a mask is rewritten
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rail_pg_eff_a <= {`RFPG_W_MASK_A{1'b0}};
            rail_pg_eff_b <= {`RFPG_W_MASK_B{1'b0}};
        end else begin
            rail_pg_eff_a <= next_eff_a;
            rail_pg_eff_b <= next_eff_b;
        end
    end

    // combined result; reset low, so a board with every rail good sees one rise
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_good_tree <= 1'b0;
        end else begin
            power_good_tree <= next_tree;
        end
    end

    // one-cycle-old copy of the tree, for its edge events
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tree_prev <= 1'b0;
        end else begin
            tree_prev <= power_good_tree;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, write 1 to clear

    // a fault event is a flag that goes from clear to set this cycle
    // a flag already set raises no second event until it is cleared
    assign irq_events[`RFPG_IRQ_FAULT_A] = |(rail_lost_a & ~fault_a);
    assign irq_events[`RFPG_IRQ_FAULT_B] = |(rail_lost_b & ~fault_b);
    assign irq_events[`RFPG_IRQ_TREE_FELL] = tree_prev & ~power_good_tree;
    assign irq_events[`RFPG_IRQ_TREE_ROSE] = ~tree_prev & power_good_tree;

    rfpg_sticky_flags #(
        .W(`RFPG_W_IRQ),
        .RST_VAL(`RFPG_RST_IRQ_STAT),
        .CLR_VAL(`RFPG_CLR_ON_ONE)
    ) u_irq_stat (
        .pclk(pclk),
        .presetn(presetn),
        .set_in(irq_events),
        .wr_en(wr_irq_stat),
        .wdata(pwdata[`RFPG_W_IRQ-1:0]),
        .flags(irq_stat)
    );

    // level output; a mask bit of 1 blocks its status bit
    // built from flip-flops only, so bus traffic cannot make it glitch
    assign irq = |(irq_stat & ~irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // read path

    // unused bits and reserved fields read as zero
    always @* begin
        next_rdata = 32'h0000_0000;
        case (idx)
            `RFPG_IDX_STAT_A: begin
                next_rdata[`RFPG_W_STAT_A-1:0] = fault_a;
            end
            `RFPG_IDX_STAT_B: begin
                next_rdata[`RFPG_W_STAT_B-1:0] = fault_b;
            end
            `RFPG_IDX_MASK_A: begin
                next_rdata[`RFPG_W_MASK_A-1:0] = mask_a;
            end
            `RFPG_IDX_MASK_B: begin
                next_rdata[`RFPG_W_MASK_B-1:0] = mask_b;
            end
            `RFPG_IDX_IRQ_STAT: begin
                next_rdata[`RFPG_W_IRQ-1:0] = irq_stat;
            end
            `RFPG_IDX_IRQ_MASK: begin
                next_rdata[`RFPG_W_IRQ-1:0] = irq_mask;
            end
            `RFPG_IDX_PG_STATE: begin
                next_rdata[`RFPG_PGS_RAW_LSB+11:`RFPG_PGS_RAW_LSB] = {rail_pg_b, rail_pg_a};
                next_rdata[`RFPG_PGS_EFF_LSB+11:`RFPG_PGS_EFF_LSB] =
                    {rail_pg_eff_b, rail_pg_eff_a};
                next_rdata[`RFPG_PGS_TREE] = power_good_tree;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // read data is caught in the setup cycle and stands through access;
    // a flag that sets during access shows on the next read instead
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        end
    end

    // error is decided from the address alone and also blocks the write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            pslverr <= ~mapped;
        end
    end

endmodule // rfpg_regs

// [bench/rfpg_regs_properties.sv]
`timescale 1ns/1ps
////////////////////////////////
// watches the bank at its ports only
module rfpg_regs_chk #(
    parameter AW = 12
) (
    // apb side
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [AW-1:0] paddr,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // rail side
    input logic [7:0] rail_lost_a,
    input logic [7:0] rail_pg_a,
    input logic [3:0] rail_pg_b,
    input logic [7:0] rail_pg_eff_a,
    input logic [3:0] rail_pg_eff_b,
    input logic power_good_tree
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // setup phase of a read of status a, and an index outside the map
    wire rd_a = psel && !penable && !pwrite && paddr[AW-1:2] == 10'h016;
    wire unmapped = paddr[AW-1:2] < 10'h016 || paddr[AW-1:2] > 10'h01c;
    // first edge after release still shows reset outputs, hence the guard
    pg_pass_a_a: assert property ($past(presetn) |->
        (rail_pg_eff_a & $past(rail_pg_a)) == $past(rail_pg_a)) else $error("good rail dropped");
    tree_good_a: assert property ($past(presetn) && &{$past(rail_pg_b), $past(rail_pg_a)}
        |-> power_good_tree) else $error("tree low with all rails good");
    tree_and_a: assert property (power_good_tree == &{rail_pg_eff_b, rail_pg_eff_a})
        else $error("tree is not the and of effective bits");
    fault_read_a: assert property (rd_a |=>
        (prdata[7:0] & $past(rail_lost_a, 2)) == $past(rail_lost_a, 2)) else $error("fault lost");
    unmapped_err_a: assert property (psel && !penable && unmapped |=> pslverr && prdata == 0)
        else $error("unmapped read not refused");
    ready_high_a: assert property (pready) else $error("pready low");
endmodule // rfpg_regs_chk
bind rfpg_regs rfpg_regs_chk #(.AW(AW)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rail_lost_a(rail_lost_a), .rail_pg_a(rail_pg_a), .rail_pg_b(rail_pg_b),
    .rail_pg_eff_a(rail_pg_eff_a), .rail_pg_eff_b(rail_pg_eff_b),
    .power_good_tree(power_good_tree));

// [bench/rfpg_rail_model.sv]
`timescale 1ns/1ps
////////////////////////////////
// rail monitors: loss pulses and power-good levels, stepped by the bench
module rfpg_rail_model (
    // clock
    input logic pclk,
    // indications toward the bank
    output logic [7:0] lost_a,
    output logic [1:0] lost_b,
    output logic [7:0] pg_a,
    output logic [3:0] pg_b
);
    // quiet and all good from time zero
    initial begin
        lost_a = 8'h00;
        lost_b = 2'h0;
        pg_a = 8'hff;
        pg_b = 4'hf;
    end
    // one cycle of lost regulation; the flag has to stick by itself
    task pulse(input logic [7:0] a, input logic [1:0] b);
        @(posedge pclk);
        lost_a <= a;
        lost_b <= b;
        @(posedge pclk);
        lost_a <= 8'h00;
        lost_b <= 2'h0;
    endtask
    // a monitor may change its verdict at any edge
    task set_pg(input logic [7:0] a, input logic [3:0] b);
        @(posedge pclk);
        pg_a <= a;
        pg_b <= b;
    endtask
endmodule // rfpg_rail_model

// [bench/rfpg_regs_tb_top.sv]
`timescale 1ns/1ps
`include "rfpg_defines.vh"
////////////////////////////////
module rfpg_regs_tb_top;
    localparam logic [9:0] st_a = `RFPG_IDX_STAT_A;
    localparam logic [9:0] st_b = `RFPG_IDX_STAT_B;
    localparam logic [9:0] mk_a = `RFPG_IDX_MASK_A;
    localparam logic [9:0] mk_b = `RFPG_IDX_MASK_B;
    localparam logic [9:0] iq_s = `RFPG_IDX_IRQ_STAT;
    localparam logic [9:0] iq_m = `RFPG_IDX_IRQ_MASK;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, irq, tree;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] lost_a, pg_a, eff_a;
    logic [1:0] lost_b;
    logic [3:0] pg_b, eff_b, pstrb;
    int n_fail = 0, compares = 0, cyc = 0;
    // clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // lane 0 carries all write data; its strobe is dropped once to see a write refused
    rfpg_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rail_lost_a(lost_a), .rail_lost_b(lost_b),
        .rail_pg_a(pg_a), .rail_pg_b(pg_b), .rail_pg_eff_a(eff_a), .rail_pg_eff_b(eff_b),
        .power_good_tree(tree), .irq(irq));
    rfpg_rail_model u_rail (.pclk(pclk), .lost_a(lost_a), .lost_b(lost_b), .pg_a(pg_a),
        .pg_b(pg_b));
    // compare and tally
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer; waits for pready, then releases
    task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench timeout ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h0, d});
    endtask
    task rd(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(q, exp, "read");
    endtask
    // outputs are registered, so give them two edges and look mid-cycle
    task see_pg(input logic [12:0] exp);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk({19'h0, tree, eff_b, eff_a}, {19'h0, exp}, "pg");
    endtask
    task see_irq(input logic x);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, irq}, {31'h0, x}, "irq");
    endtask
    task t_reset;
        for (int i = 0; i < 4; i++) rd(st_a + i[9:0], 32'h0);
        apb(1'b0, 10'h000, 32'h0);
        chk({31'h0, e}, 32'h1, "slverr");
        $display("t_reset done");
    endtask
    task t_fault;
        u_rail.pulse(8'h81, 2'h2);
        rd(st_a, 32'h81);
        rd(st_b, 32'h02);
        wr(st_a, 8'hff);
        rd(st_a, 32'h81);
        wr(st_a, 8'h80);
        rd(st_a, 32'h80);
        wr(st_a, 8'h00);
        wr(st_b, 8'h00);
        rd(st_a, 32'h0);
        rd(st_b, 32'h0);
        $display("t_fault done");
    endtask
    task t_irq;
        wr(iq_s, 8'h0f);
        wr(iq_m, 8'h0e);
        see_irq(1'b0);
        u_rail.pulse(8'h04, 2'h0);
        see_irq(1'b1);
        rd(iq_s, 32'h01);
        wr(iq_m, 8'h0f);
        see_irq(1'b0);
        wr(iq_m, 8'h0e);
        see_irq(1'b1);
        wr(iq_s, 8'h01);
        see_irq(1'b0);
        wr(st_a, 8'h00);
        $display("t_irq done");
    endtask
    task t_mask;
        see_pg({1'b1, 4'hf, 8'hff});
        u_rail.set_pg(8'h7f, 4'hf);
        see_pg({1'b0, 4'hf, 8'h7f});
        wr(mk_a, 8'h80);
        see_pg({1'b1, 4'hf, 8'hff});
        u_rail.set_pg(8'h7f, 4'h7);
        see_pg({1'b0, 4'h7, 8'hff});
        wr(mk_b, 8'hff);
        rd(mk_b, 32'h0f);
        see_pg({1'b1, 4'hf, 8'hff});
        u_rail.set_pg(8'h00, 4'h0);
        wr(mk_a, 8'hff);
        see_pg({1'b1, 4'hf, 8'hff});
        wr(mk_a, 8'hfe);
        see_pg({1'b0, 4'hf, 8'hfe});
        rd(`RFPG_IDX_PG_STATE, 32'h00ff_e000);
        rd(iq_s, 32'h0c);
        pstrb <= 4'h0;
        wr(mk_a, 8'h00);
        pstrb <= 4'hf;
        rd(mk_a, 32'hfe);
        $display("t_mask done");
    endtask
    task wrap_up;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // hang guard, far above the roughly 150 cycles the tests need
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            $display("[ERR] %0t timeout", $time);
            wrap_up;
        end
    end
    // main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_fault;
        t_irq;
        t_mask;
        wrap_up;
    end
endmodule // rfpg_regs_tb_top
